// ---- hw/load_meter_pkg.sv ----
package load_meter_pkg;

	// Register offsets
	localparam logic [7:0] MASK23_ADDR       = 8'h20;
	localparam logic [7:0] CORE_SEL_ADDR     = 8'h21;
	localparam logic [7:0] RESULT_HIGH_ADDR  = 8'h22;
	localparam logic [7:0] RESULT_LOW_ADDR   = 8'h23;

	// Mask field positions
	localparam int CORE3_PG_BIT   = 6;
	localparam int CORE3_OC_BIT   = 4;
	localparam int CORE2_PG_BIT   = 2;
	localparam int CORE2_OC_BIT   = 0;

	// Reset values
	localparam logic [7:0] MASK23_RESET    = 8'h55;
	localparam logic [1:0] CORE_SEL_RESET  = 2'h0;
	localparam logic [9:0] RESULT_RESET    = 10'h000;
	localparam logic       READY_MASK_RESET = 1'b1;

	// Writable bits of the mask register (7 and 3 are R/W reserved)
	localparam logic [7:0] MASK23_WMASK    = 8'hdd;

	// Result scaling
	localparam int RESULT_WIDTH   = 10;
	localparam int LSB_MILLIAMP   = 20;
	localparam int MAX_MILLIAMP   = 20000;
	localparam logic [9:0] RESULT_MAX = 10'(MAX_MILLIAMP / LSB_MILLIAMP);

endpackage : load_meter_pkg

// ---- hw/result_hold.sv ----
`timescale 1ns/1ps
// Holds a complete measurement result, loaded in one cycle
module result_hold #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	// Load side
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] din,
	// Held value
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] hold_r;

	// Both halves captured on the same edge
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			hold_r <= '0;
		else if (load)
			hold_r <= din;
	end

	assign dout = hold_r;

endmodule : result_hold

// ---- hw/rail_irq_mask_load_meter_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] Bit 6 blocks core 3 power-good, reset 1
// [R2] Bit 4 blocks core 3 overcurrent, reset 1
// [R3] Bit 2 blocks core 2 power-good, reset 1
// [R4] Bit 0 blocks core 2 overcurrent
// [R5] Masks never alter raw status bits
// [R6] Select field bits 1:0 picks core, reset 0
// [R7] Every select write starts a measurement
// [R8] High result: bits 9:8, upper reads zero
// [R9] Low result: bits 7:0, reset zero
// [R10] Result is 20 mA per LSB, 20 A max
// [R11] Completion raises ready event, own mask reset 1
// [R12] Both result halves update together, then hold
// [R13] Host reads results after ready indication
module rail_irq_mask_load_meter_regs #(
	parameter int RESULT_WIDTH = load_meter_pkg::RESULT_WIDTH
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    sys_rst,
	// Register port from the serial interface
	input  wire logic [7:0]              reg_addr,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [7:0]              reg_wdata,
	output logic      [7:0]              reg_rdata,
	// Ready mask bit, held in the top-level mask register outside
	input  wire logic                    ready_irq_block,
	// Raw conditions from the converter cores
	input  wire logic                    core3_powergood_raw,
	input  wire logic                    core3_overcurrent_raw,
	input  wire logic                    core2_powergood_raw,
	input  wire logic                    core2_overcurrent_raw,
	// Gated events toward the interrupt flag register
	output logic                         core3_powergood_event,
	output logic                         core3_overcurrent_event,
	output logic                         core2_powergood_event,
	output logic                         core2_overcurrent_event,
	output logic                         meter_ready_event,
	// Raw status passed through unmasked
	output logic                         core3_powergood_stat,
	output logic                         core3_overcurrent_stat,
	output logic                         core2_powergood_stat,
	output logic                         core2_overcurrent_stat,
	// Analog measurement engine
	output logic                         meas_start,
	output logic      [1:0]              meas_core,
	input  wire logic                    meas_done,
	input  wire logic [RESULT_WIDTH-1:0] meas_value
);

	logic [7:0]              mask23_r;
	logic [7:0]              mask23_nxt;
	logic [5:0]              sel_rsvd_r;
	logic [1:0]              core_sel_r;
	logic                    start_r;
	logic [7:0]              rdata_r;
	logic [7:0]              rdata_nxt;
	logic [RESULT_WIDTH-1:0] result;
	logic [RESULT_WIDTH-1:0] meas_clamped;
	logic                    wr_mask;
	logic                    wr_sel;

	// Address decode
	assign wr_mask = reg_wr && (reg_addr == load_meter_pkg::MASK23_ADDR);
	assign wr_sel  = reg_wr && (reg_addr == load_meter_pkg::CORE_SEL_ADDR);

	// Only writable bits take new data
	assign mask23_nxt = (reg_wdata & load_meter_pkg::MASK23_WMASK)
		| (mask23_r & ~load_meter_pkg::MASK23_WMASK);

	// Mask register, blocking bits set at reset
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			mask23_r <= load_meter_pkg::MASK23_RESET; // [R1] [R2] [R3] [R4]
		else if (wr_mask)
			mask23_r <= mask23_nxt;
	end

	// Core select register and start pulse on every write
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			core_sel_r <= load_meter_pkg::CORE_SEL_RESET; // [R6]
			sel_rsvd_r <= 6'h00;
			start_r    <= 1'b0;
		end
		else
		begin
			start_r <= wr_sel; // [R7]
			if (wr_sel)
			begin
				core_sel_r <= reg_wdata[1:0]; // [R6]
				sel_rsvd_r <= reg_wdata[7:2];
			end
		end
	end

	assign meas_start = start_r;
	assign meas_core  = core_sel_r; // [R7]

	// Saturate to the full-scale code
	assign meas_clamped = (meas_value > RESULT_WIDTH'(load_meter_pkg::RESULT_MAX)) ?
		RESULT_WIDTH'(load_meter_pkg::RESULT_MAX) : meas_value; // [R10]

	// Result held as one word so both halves belong together
	result_hold #(
		.WIDTH (RESULT_WIDTH)
	) u_result_hold (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.load    (meas_done), // [R12]
		.din     (meas_clamped),
		.dout    (result)
	);

	// Ready event registered on the same edge as capture, gated by its own mask
	logic ready_r;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			ready_r <= 1'b0;
		else
			ready_r <= meas_done;
	end
	assign meter_ready_event = ready_r && !ready_irq_block; // [R11]

	// Events gated, raw status untouched by masks
	assign core3_powergood_event   = core3_powergood_raw
		&& !mask23_r[load_meter_pkg::CORE3_PG_BIT]; // [R1]
	assign core3_overcurrent_event = core3_overcurrent_raw
		&& !mask23_r[load_meter_pkg::CORE3_OC_BIT]; // [R2]
	assign core2_powergood_event   = core2_powergood_raw
		&& !mask23_r[load_meter_pkg::CORE2_PG_BIT]; // [R3]
	assign core2_overcurrent_event = core2_overcurrent_raw
		&& !mask23_r[load_meter_pkg::CORE2_OC_BIT]; // [R4]
	assign core3_powergood_stat    = core3_powergood_raw; // [R5]
	assign core3_overcurrent_stat  = core3_overcurrent_raw; // [R5]
	assign core2_powergood_stat    = core2_powergood_raw; // [R5]
	assign core2_overcurrent_stat  = core2_overcurrent_raw; // [R5]

	// Read mux
	always_comb
	begin
		rdata_nxt = 8'h00;
		unique case (reg_addr)
			load_meter_pkg::MASK23_ADDR:      rdata_nxt = mask23_r;
			load_meter_pkg::CORE_SEL_ADDR:    rdata_nxt = {sel_rsvd_r, core_sel_r};
			load_meter_pkg::RESULT_HIGH_ADDR: rdata_nxt = {6'h00, result[9:8]}; // [R8]
			load_meter_pkg::RESULT_LOW_ADDR:  rdata_nxt = result[7:0]; // [R9]
			default:                          rdata_nxt = 8'h00;
		endcase
	end

	// Read data registered on the read strobe
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			rdata_r <= 8'h00;
		else if (reg_rd)
			rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;

	// Checks on reset values
	a_mask_reset_val: assert property (@(posedge mclk) // [R1]
		$past(sys_rst) |-> mask23_r == load_meter_pkg::MASK23_RESET)
		else $error("mask register reset value wrong");

	a_sel_reset_val: assert property (@(posedge mclk) // [R6]
		$past(sys_rst)
		|-> core_sel_r == load_meter_pkg::CORE_SEL_RESET)
		else $error("select reset value wrong");

	a_result_reset_val: assert property (@(posedge mclk) // [R9]
		$past(sys_rst)
		|-> result == load_meter_pkg::RESULT_RESET)
		else $error("result reset value wrong");

	a_start_reset_low: assert property (@(posedge mclk) // [R7]
		$past(sys_rst)
		|-> !meas_start)
		else $error("start pulse out of reset");

	a_ready_reset_low: assert property (@(posedge mclk) // [R11]
		$past(sys_rst)
		|-> !meter_ready_event)
		else $error("ready event out of reset");

	a_evt_reset_blocked: assert property (@(posedge mclk) // [R1]
		$past(sys_rst)
		|-> !core3_powergood_event && !core3_overcurrent_event
			&& !core2_powergood_event && !core2_overcurrent_event)
		else $error("event not blocked after reset");

	// Checks on mask gating
	a_core3_pg_gate: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
		core3_powergood_event == (core3_powergood_raw && !mask23_r[6]))
		else $error("core 3 power-good gating wrong");

	a_core3_oc_gate: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		mask23_r[4] |-> !core3_overcurrent_event)
		else $error("core 3 overcurrent not blocked");

	a_core3_oc_pass: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
		(core3_overcurrent_raw && !mask23_r[4])
		|-> core3_overcurrent_event)
		else $error("core 3 overcurrent not raised");

	a_core2_pg_gate: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
		(core2_powergood_raw && !mask23_r[2]) |-> core2_powergood_event)
		else $error("core 2 power-good not raised");

	a_core2_pg_block: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
		mask23_r[2]
		|-> !core2_powergood_event)
		else $error("core 2 power-good not blocked");

	a_core2_oc_gate: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
		core2_overcurrent_event == (core2_overcurrent_raw && !mask23_r[0]))
		else $error("core 2 overcurrent gating wrong");

	a_raw_stat_pass: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		core3_overcurrent_stat == core3_overcurrent_raw
		&& core2_powergood_stat == core2_powergood_raw)
		else $error("raw status altered");

	a_raw_stat_rest: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
		core3_powergood_stat == core3_powergood_raw
		&& core2_overcurrent_stat == core2_overcurrent_raw)
		else $error("raw status altered");

	// Checks on the mask register itself
	a_mask_write: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
		wr_mask
		|=> mask23_r[6] == $past(reg_wdata[6]) && mask23_r[0] == $past(reg_wdata[0]))
		else $error("mask write not taken");

	a_mask_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
		!$past(wr_mask) && !$past(sys_rst)
		|-> $stable(mask23_r))
		else $error("mask changed without write");

	a_mask_rsvd_zero: assert property (@(posedge mclk) disable iff (sys_rst) // [R3]
		mask23_r[5] == 1'b0
		&& mask23_r[1] == 1'b0)
		else $error("read-only mask bits not zero");

	// Checks on select and start
	a_sel_write_start: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
		wr_sel |=> meas_start && meas_core == $past(reg_wdata[1:0]))
		else $error("select write did not start measurement");

	a_start_single: assert property (@(posedge mclk) disable iff (sys_rst) // [R7]
		!$past(wr_sel)
		|-> !meas_start)
		else $error("start without select write");

	a_sel_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R6]
		!$past(wr_sel) && !$past(sys_rst)
		|-> $stable(core_sel_r))
		else $error("select changed without write");

	// Checks on the held result
	a_result_hold_stable: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
		!$past(meas_done) && !$past(sys_rst) |-> $stable(result))
		else $error("result changed without measurement");

	a_result_load: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
		meas_done
		|=> result == $past(meas_clamped))
		else $error("result not loaded");

	a_result_max: assert property (@(posedge mclk) disable iff (sys_rst) // [R10]
		result <= load_meter_pkg::RESULT_MAX)
		else $error("result above full scale");

	// Checks on the ready event
	a_ready_follows: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
		meas_done && !ready_irq_block |=> meter_ready_event)
		else $error("ready event missing");

	a_ready_blocked: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
		ready_irq_block
		|-> !meter_ready_event)
		else $error("ready event not blocked");

	a_ready_cause: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
		meter_ready_event
		|-> $past(meas_done))
		else $error("ready event without measurement");

	// Checks on read data
	a_high_reserved: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		reg_rd && reg_addr == load_meter_pkg::RESULT_HIGH_ADDR
		|=> reg_rdata[7:2] == 6'h00)
		else $error("reserved result bits not zero");

	a_high_read: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
		reg_rd && reg_addr == load_meter_pkg::RESULT_HIGH_ADDR
		|=> reg_rdata[1:0] == $past(result[9:8]))
		else $error("high result read wrong");

	a_low_read: assert property (@(posedge mclk) disable iff (sys_rst) // [R9]
		reg_rd && reg_addr == load_meter_pkg::RESULT_LOW_ADDR
		|=> reg_rdata == $past(result[7:0]))
		else $error("low result read wrong");

	a_rdata_hold: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
		!$past(reg_rd) && !$past(sys_rst)
		|-> $stable(reg_rdata))
		else $error("read data changed without read");

endmodule : rail_irq_mask_load_meter_regs

// ---- bench/meas_engine_model.sv ----
`timescale 1ns/1ps
// Stand-in for the analog engine: answers each start after DELAY cycles
module meas_engine_model #(
	parameter int DELAY = 3
) (
	// Clock
	input  wire logic       mclk,
	// Start request from the register block
	input  wire logic       meas_start,
	input  wire logic [1:0] meas_core,
	input  wire logic [9:0] code_in,
	// Result toward the register block
	output logic            meas_done  = 1'b0,
	output logic      [9:0] meas_value = 10'h000
);
	int cnt = 0;

	// Value is only valid with done; otherwise it toggles to expose bad capture
	always_ff @(posedge mclk)
	begin
		meas_done  <= 1'b0;
		meas_value <= ~meas_value;
		if (meas_start)
			cnt <= DELAY;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (cnt == 1)
		begin
			meas_done  <= 1'b1;
			meas_value <= code_in;
		end
	end
endmodule : meas_engine_model

// ---- bench/rail_irq_mask_load_meter_regs_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the rail mask and load meter registers
module rail_irq_mask_load_meter_regs_tb;
	typedef struct {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_s;
	logic       mclk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, ready_irq_block = 1;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rd;
	logic [3:0] raw = 0, evt, stat;
	logic       meter_ready_event, meas_start, meas_done;
	logic [1:0] meas_core;
	logic [9:0] meas_value, code_in = 0;
	int         failures = 0, n_compared = 0, hits;
	row_s       rows[9] = '{'{0, 8'h20, 8'h00, 8'h55}, '{0, 8'h21, 8'h00, 8'h00},
		'{0, 8'h22, 8'h00, 8'h00}, '{0, 8'h23, 8'h00, 8'h00}, '{1, 8'h20, 8'hff, 8'hdd},
		'{1, 8'h21, 8'hfc, 8'hfc}, '{1, 8'h22, 8'hff, 8'h00}, '{1, 8'h20, 8'h00, 8'h00},
		'{0, 8'h7f, 8'h00, 8'h00}};

	// Clock
	always #4 mclk = ~mclk;

	rail_irq_mask_load_meter_regs i_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ready_irq_block(ready_irq_block), .core3_powergood_raw(raw[3]),
		.core3_overcurrent_raw(raw[2]), .core2_powergood_raw(raw[1]),
		.core2_overcurrent_raw(raw[0]), .core3_powergood_event(evt[3]),
		.core3_overcurrent_event(evt[2]), .core2_powergood_event(evt[1]),
		.core2_overcurrent_event(evt[0]), .meter_ready_event(meter_ready_event),
		.core3_powergood_stat(stat[3]), .core3_overcurrent_stat(stat[2]),
		.core2_powergood_stat(stat[1]), .core2_overcurrent_stat(stat[0]),
		.meas_start(meas_start), .meas_core(meas_core), .meas_done(meas_done),
		.meas_value(meas_value));

	meas_engine_model #(.DELAY(3)) i_engine (.mclk(mclk), .meas_start(meas_start),
		.meas_core(meas_core), .code_in(code_in), .meas_done(meas_done),
		.meas_value(meas_value));

	task print_verdict;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task chk(input logic [9:0] got, input logic [9:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1;
		@(negedge mclk);
		reg_wr = 0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge mclk);
		reg_addr = addr;
		reg_rd = 1;
		@(negedge mclk);
		reg_rd = 0;
		data = reg_rdata;
	endtask : rd_reg

	// Start a measurement, count ready pulses, then read both result halves
	task meas(input logic [1:0] core, input logic [9:0] code, input logic blk,
		input logic [9:0] exp);
		ready_irq_block = blk;
		code_in = code;
		hits = 0;
		wr_reg(8'h21, {6'h00, core});
		chk(10'(meas_start), 10'h001);
		chk(10'(meas_core), 10'(core));
		repeat (12)
		begin
			@(negedge mclk);
			hits += int'(meter_ready_event);
		end
		chk(10'(hits), 10'(!blk));
		rd_reg(8'h22, rd);
		chk(10'(rd), {8'h00, exp[9:8]});
		rd_reg(8'h23, rd);
		chk(10'(rd), 10'(exp[7:0]));
	endtask : meas

	// Main sequence: table rows, then mask gating, measurements and a second reset
	initial
	begin
		repeat (2) @(negedge mclk);
		sys_rst = 0;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr_reg(rows[i].addr, rows[i].wdata);
			rd_reg(rows[i].addr, rd);
			chk(10'(rd), 10'(rows[i].exp));
		end
		raw = 4'hf;
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(8'h01 << (2 * i), 8'h01 << (2 * i) | 8'h00);
			wr_reg(8'h20, 8'h01 << (2 * i));
			chk(10'(evt), 10'(4'(~(4'h1 << i))));
			chk(10'(stat), 10'h00f);
		end
		meas(2'h3, 10'h2a5, 1'b0, 10'h2a5);
		meas(2'h2, 10'h3ff, 1'b1, 10'h3e8);
		sys_rst = 1;
		repeat (2) @(negedge mclk);
		sys_rst = 0;
		rd_reg(8'h20, rd);
		chk(10'(rd), 10'h055);
		rd_reg(8'h23, rd);
		chk(10'(rd), 10'h000);
		print_verdict;
	end

	// Watchdog well beyond the expected run of about 90 cycles
	initial
	begin
		#20000;
		failures++;
		print_verdict;
	end
endmodule : rail_irq_mask_load_meter_regs_tb
